// >>> hdl/wdt_top.sv
/*
  Windowed watchdog timer: prescaler, postscaler, enable logic, window check,
  sleep wake-up and sticky status flags.
  Assumes core events arrive as one-cycle pulses on clk_in; the oscillator is
  modelled by a tick derived from clk_in, so no second domain exists.
*/
`include "wdt_map.svh"
module wdt_top (
  input  wire logic                        clk_in,
  input  wire logic                        rst_in,
  input  wire logic                        ce_in,
  input  wire wdt_pkg::wdt_config_word_type cfg_in,
  input  wire wdt_pkg::wdt_core_event_type  evt_in,
  input  wire logic                        sw_enable_set_in,
  input  wire logic                        sw_enable_clr_in,
  input  wire logic                        flag_clr_in,
  input  wire logic                        sleep_clr_in,
  input  wire logic                        idle_clr_in,
  output logic                             sw_watchdog_enable_out,
  output logic                             timeout_flag_out,
  output logic                             sleep_flag_out,
  output logic                             idle_flag_out,
  output logic                             osc_on_out,
  output logic                             wake_out,
  output logic                             device_reset_out,
  output logic [1:0]                       mode_out
);
  import wdt_pkg::*;

  logic        tick;
  logic        enabled;
  logic        scaler_clear;
  logic        pre_done;
  logic        post_done;
  logic        early_clear;
  logic [21:0] elapsed_span;
  logic [21:0] full_span;
  logic [6:0]  pre_ff;
  logic [14:0] post_ff;
  logic        sw_en_ff;
  wdt_mode_type mode_ff;
  wdt_mode_type nxt_mode;

  // Prescale terminal count from the select bit
  function automatic logic [6:0] pre_last(input logic sel);
    pre_last = sel ? 7'(`WDT_PRE_LARGE - 1) : 7'(`WDT_PRE_SMALL - 1);
  endfunction : pre_last

  // Postscale terminal count: 2^sel - 1
  function automatic logic [14:0] post_last(input logic [3:0] sel);
    post_last = 15'((16'h0001 << sel) - 16'h0001);
  endfunction : post_last

  // Count in oscillator ticks; the short prescaler only uses its low five bits,
  // so the window stays a true quarter of the period at every postscale
  function automatic logic [21:0] span_of(input logic        sel,
                                          input logic [14:0] post,
                                          input logic [6:0]  pre);
    span_of = sel ? {post, pre} : {2'b00, post, pre[4:0]};
  endfunction : span_of

  // Oscillator runs whenever the watchdog is enabled
  assign enabled = cfg_in.hw_watchdog_enable || sw_en_ff;

  wdt_tick_gen u_tick (
    .clk_in    (clk_in),
    .rst_in    (rst_in),
    .ce_in     (ce_in),
    .osc_on_in (enabled),
    .tick_out  (tick)
  );

  // Every clearing source; the clear instruction only in run, another wake only in rest; a timeout restarts the count too
  assign scaler_clear = evt_in.clock_switch_done
                     || evt_in.power_save_instr
                     || (mode_ff != WDT_RUN && (evt_in.wake_other || post_done))
                     || (mode_ff == WDT_RUN && evt_in.watchdog_clear_instr)
                     || !enabled
                     || (mode_ff == WDT_RUN && post_done);

  assign pre_done  = tick && (pre_ff == pre_last(cfg_in.prescale_select));
  assign post_done = pre_done && (post_ff == post_last(cfg_in.postscale_select));

  // Elapsed and full counts on one scale for either prescaler size
  assign elapsed_span = span_of(cfg_in.prescale_select, post_ff, pre_ff);
  assign full_span    = span_of(cfg_in.prescale_select, post_last(cfg_in.postscale_select),
                                pre_last(cfg_in.prescale_select));

  // Window: a clear before three quarters of the period is too early; four times
  // the elapsed count fits 24 bits, so neither side of the compare wraps
  assign early_clear = !cfg_in.window_disable && mode_ff == WDT_RUN
                    && evt_in.watchdog_clear_instr && enabled
                    && ({elapsed_span, 2'b00}
                        < ({2'b00, full_span} * 24'h000003) + 24'h000003);

  // Prescaler counter
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pre_ff <= 7'h00;
    end else if (ce_in) begin
      if (scaler_clear || pre_done) begin
        pre_ff <= 7'h00;
      end else if (tick) begin
        pre_ff <= pre_ff + 7'h01;
      end
    end
  end

  // Postscaler counter
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      post_ff <= 15'h0000;
    end else if (ce_in) begin
      if (scaler_clear) begin
        post_ff <= 15'h0000;
      end else if (pre_done) begin
        post_ff <= post_ff + 15'h0001;
      end
    end
  end

  // Software enable, cleared by reset; set wins over clear
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      sw_en_ff <= `WDT_RST_SWEN;
    end else if (ce_in) begin
      if (sw_enable_set_in) begin
        sw_en_ff <= 1'b1;
      end else if (sw_enable_clr_in) begin
        sw_en_ff <= 1'b0;
      end
    end
  end

  // Core mode tracking
  always_comb begin
    nxt_mode = mode_ff;
    case (mode_ff)
      WDT_RUN: begin
        if (evt_in.power_save_instr) begin
          nxt_mode = evt_in.power_save_is_idle ? WDT_IDLE : WDT_SLEEP;
        end
      end
      WDT_SLEEP, WDT_IDLE: begin
        if (post_done || evt_in.wake_other) begin
          nxt_mode = WDT_RUN;
        end
      end
      default: nxt_mode = WDT_RUN;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      mode_ff <= WDT_RUN;
    end else if (ce_in) begin
      mode_ff <= nxt_mode;
    end
  end

  // Timeout flag is sticky; a reset-causing event keeps it across rst_in
  // because the flag sits in the always-on reset-status domain
  always_ff @(posedge clk_in) begin
    if (ce_in) begin
      if (mode_ff == WDT_RUN && (post_done || early_clear)) begin
        timeout_flag_out <= 1'b1;
      end else if (flag_clr_in) begin
        timeout_flag_out <= 1'b0;
      end
    end
  end

  // Sleep and idle status bits: hardware sets on entry, software or rst_in clears
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      sleep_flag_out <= 1'b0;
      idle_flag_out  <= 1'b0;
    end else if (ce_in) begin
      if (mode_ff == WDT_RUN && nxt_mode == WDT_SLEEP) begin
        sleep_flag_out <= 1'b1;
      end else if (sleep_clr_in) begin
        sleep_flag_out <= 1'b0;
      end
      if (mode_ff == WDT_RUN && nxt_mode == WDT_IDLE) begin
        idle_flag_out <= 1'b1;
      end else if (idle_clr_in) begin
        idle_flag_out <= 1'b0;
      end
    end
  end

  // Registered outputs: reset and wake pulses, oscillator enable, mode
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      wake_out               <= 1'b0;
      device_reset_out       <= 1'b0;
      osc_on_out             <= 1'b0;
      sw_watchdog_enable_out <= 1'b0;
      mode_out               <= 2'h0;
    end else if (ce_in) begin
      wake_out               <= (mode_ff != WDT_RUN) && post_done;
      device_reset_out       <= (mode_ff == WDT_RUN) && (post_done || early_clear);
      osc_on_out             <= enabled;
      sw_watchdog_enable_out <= sw_en_ff;
      mode_out               <= {mode_ff == WDT_IDLE, mode_ff == WDT_SLEEP};
    end
  end

  // Checks
  sequence s_run_timeout;
    ce_in && mode_ff == WDT_RUN && post_done;
  endsequence

  AST_RUN_TIMEOUT_RESETS: assert property (@(posedge clk_in) disable iff (rst_in)
    s_run_timeout |=> device_reset_out && timeout_flag_out)
    else $error("run timeout did not reset");

  AST_SLEEP_TIMEOUT_WAKES: assert property (@(posedge clk_in) disable iff (rst_in)
    (ce_in && mode_ff != WDT_RUN && post_done) |=> wake_out && !device_reset_out
      && mode_ff == WDT_RUN)
    else $error("sleep timeout did not wake");

  AST_EARLY_CLEAR: assert property (@(posedge clk_in) disable iff (rst_in)
    (ce_in && early_clear) |=> device_reset_out)
    else $error("early clear did not reset");

  AST_NO_WINDOW: assert property (@(posedge clk_in) disable iff (rst_in)
    (ce_in && cfg_in.window_disable && mode_ff == WDT_RUN && evt_in.watchdog_clear_instr
      && !post_done) |=> !device_reset_out)
    else $error("window check active while disabled");

  AST_FLAG_STICKY: assert property (@(posedge clk_in) disable iff (rst_in)
    (timeout_flag_out && !flag_clr_in) |=> timeout_flag_out)
    else $error("timeout flag dropped");

  AST_SW_RESET: assert property (@(posedge clk_in)
    rst_in |=> !sw_en_ff)
    else $error("sw enable survived reset");

  AST_HW_ENABLE: assert property (@(posedge clk_in) disable iff (rst_in)
    (ce_in && cfg_in.hw_watchdog_enable) |=> osc_on_out)
    else $error("hw enable ignored");

  AST_SW_ONLY: assert property (@(posedge clk_in) disable iff (rst_in)
    (!cfg_in.hw_watchdog_enable && !sw_en_ff && ce_in) |=> pre_ff == 7'h00 && post_ff == 15'h0000)
    else $error("counting while disabled");

  AST_CLR_INSTR: assert property (@(posedge clk_in) disable iff (rst_in)
    (ce_in && mode_ff == WDT_RUN && evt_in.watchdog_clear_instr)
      |=> pre_ff == 7'h00 && post_ff == 15'h0000)
    else $error("clear did not zero scalers");

  AST_PWRSAVE_CLR: assert property (@(posedge clk_in) disable iff (rst_in)
    (ce_in && (evt_in.power_save_instr || evt_in.clock_switch_done)) |=> pre_ff == 7'h00
      && post_ff == 15'h0000)
    else $error("scalers not cleared");

  AST_PRE_LIMIT: assert property (@(posedge clk_in) disable iff (rst_in)
    !cfg_in.prescale_select && $stable(cfg_in) |-> pre_ff <= 7'(`WDT_PRE_SMALL - 1))
    else $error("prescaler overran");

  // Leaving a rest state, by timeout or by another wake source
  sequence s_rest_exit;
    ce_in && mode_ff != WDT_RUN && (post_done || evt_in.wake_other);
  endsequence

  AST_EXIT_CLEARS: assert property (@(posedge clk_in) disable iff (rst_in)
    s_rest_exit |=> mode_ff == WDT_RUN && pre_ff == 7'h00 && post_ff == 15'h0000)
    else $error("exit from rest did not clear scalers");

  AST_REST_FLAG_SET: assert property (@(posedge clk_in) disable iff (rst_in)
    (ce_in && mode_ff == WDT_RUN && evt_in.power_save_instr) |=> sleep_flag_out || idle_flag_out)
    else $error("rest entry left no status bit");

  AST_SLEEP_FLAG_KEPT: assert property (@(posedge clk_in) disable iff (rst_in)
    (sleep_flag_out && !sleep_clr_in) |=> sleep_flag_out)
    else $error("sleep status bit dropped");

  AST_IDLE_FLAG_KEPT: assert property (@(posedge clk_in) disable iff (rst_in)
    (idle_flag_out && !idle_clr_in) |=> idle_flag_out)
    else $error("idle status bit dropped");

  AST_OSC_OFF: assert property (@(posedge clk_in) disable iff (rst_in)
    (ce_in && !cfg_in.hw_watchdog_enable && !sw_en_ff) |=> !osc_on_out)
    else $error("oscillator on while disabled");

  // Clock enable low must hold both counters and the mode
  AST_FREEZE: assert property (@(posedge clk_in) disable iff (rst_in)
    !ce_in |=> $stable(pre_ff) && $stable(post_ff) && $stable(mode_ff))
    else $error("state moved while clock enable low");

endmodule : wdt_top

// >>> hdl/wdt_map.svh
/*
  Timing counts, field positions and reset values for the windowed watchdog.
  Assumes inclusion by bare name from files under hdl/.
*/
`ifndef WDT_MAP_SVH
`define WDT_MAP_SVH

// Core clock and low-power oscillator figures
`define WDT_CLK_HZ           25000000
`define WDT_OSC_HZ           32000
// Low-power oscillator tick: core cycles per oscillator period, rounded down
`define WDT_OSC_DIV          (`WDT_CLK_HZ / `WDT_OSC_HZ)
// Prescaler ratios
`define WDT_PRE_SMALL        32
`define WDT_PRE_LARGE        128
// Base timeouts in microseconds; no check refers to them
`define WDT_BASE_SMALL_US    1000
`define WDT_BASE_LARGE_US    4000
// Configuration word field positions
`define WDT_CFG_POST_LSB     0
`define WDT_CFG_PRE_BIT      4
`define WDT_CFG_HWEN_BIT     5
`define WDT_CFG_WINDOW_DIS_BIT 6
// Reset values
`define WDT_RST_SWEN         1'b0
`define WDT_RST_FLAG         1'b0

`endif

// >>> hdl/wdt_pkg.sv
/*
  Types shared by the windowed watchdog files.
  Assumes the map header is compiled alongside.
*/
package wdt_pkg;

  // Static configuration word, as fused
  typedef struct packed {
    logic       window_disable;
    logic       hw_watchdog_enable;
    logic       prescale_select;
    logic [3:0] postscale_select;
  } wdt_config_word_type;

  // Core events that touch the watchdog
  typedef struct packed {
    logic watchdog_clear_instr;
    logic power_save_instr;
    logic power_save_is_idle;
    logic wake_other;
    logic clock_switch_done;
  } wdt_core_event_type;

  // Run state of the core as seen by the watchdog
  typedef enum logic [2:0] {
    WDT_RUN   = 3'b001,
    WDT_SLEEP = 3'b010,
    WDT_IDLE  = 3'b100
  } wdt_mode_type;

endpackage : wdt_pkg

// >>> hdl/wdt_tick_gen.sv
/*
  Low-power oscillator model: makes a one-cycle tick at the nominal oscillator
  rate while enabled. Assumes one core clock and a synchronous reset.
*/
`include "wdt_map.svh"
module wdt_tick_gen (
  input  wire logic clk_in,
  input  wire logic rst_in,
  input  wire logic ce_in,
  input  wire logic osc_on_in,
  output logic      tick_out
);
  import wdt_pkg::*;

  localparam int unsigned DIV = `WDT_OSC_DIV;
  logic [9:0] cnt_ff;

  // Divider halts and resets when the oscillator is off to save power
  always_ff @(posedge clk_in) begin
    if (rst_in || (ce_in && !osc_on_in)) begin
      cnt_ff   <= 10'h000;
      tick_out <= 1'b0;
    end else if (ce_in) begin
      tick_out <= (cnt_ff == 10'(DIV - 1));
      cnt_ff   <= (cnt_ff == 10'(DIV - 1)) ? 10'h000 : cnt_ff + 10'h001;
    end
  end

endmodule : wdt_tick_gen

// >>> tb/wdt_core_model.sv
/*
  Core model: issues clear, power-save and clock-switch events as one-cycle
  pulses. Assumes callers stand on the falling edge of clk_in.
*/
module wdt_core_model (
  input  wire logic                   clk_in,
  output wdt_pkg::wdt_core_event_type evt_out
);
  timeunit 1ns;
  timeprecision 1ps;
  import wdt_pkg::*;

  // Event codes, msb first: clear, power-save, idle, other wake, clock switch
  localparam logic [4:0] EV_CLEAR = 5'h10;
  localparam logic [4:0] EV_SLEEP = 5'h08;
  localparam logic [4:0] EV_SWTCH = 5'h01;
  localparam logic [4:0] EV_IDLE  = 5'h0c;
  localparam logic [4:0] EV_WAKE  = 5'h02;

  // No instruction in flight until the bench asks for one
  initial evt_out = '0;

  // One instruction lasts one core cycle, never longer
  task automatic issue(input logic [4:0] bits);
    evt_out = bits;
    @(negedge clk_in);
    evt_out = '0;
  endtask : issue
endmodule : wdt_core_model

// >>> tb/test_windowed_watchdog_timer.sv
/*
  Self-checking bench for the windowed watchdog: timeout, clear, sleep wake-up,
  window violation and software enable. Assumes the core model beside it.
*/
`include "wdt_map.svh"
module test_windowed_watchdog_timer;
  timeunit 1ns;
  timeprecision 1ps;
  import wdt_pkg::*;

  // Period at divide-by-32, 1:1; one oscillator tick of slack for phase
  localparam int P   = `WDT_OSC_DIV * `WDT_PRE_SMALL;
  localparam int TOL = 800;
  typedef struct {logic [31:0] kind; int lo; int hi;} note_type;

  logic                clk_in = 1'b0;
  logic                rst_in = 1'b1;
  wdt_config_word_type cfg    = 7'h60;
  wdt_core_event_type  evt;
  logic                sw_set = 1'b0, sw_clr = 1'b0, flag_clr = 1'b0, slp_clr = 1'b0;
  logic                ce = 1'b1, idl_clr = 1'b0;
  logic                sw_en, flag, slp, idl, osc, wake, drst;
  logic [1:0]          mode;
  logic [7:0]          rnd = 8'h29;
  int                  cyc = 0, bad_count = 0, comparisons = 0;
  note_type            notes[$];
  note_type            n;

  always #20 clk_in = ~clk_in;

  wdt_core_model u_core (.clk_in(clk_in), .evt_out(evt));

  wdt_top u_dut (
    .clk_in(clk_in), .rst_in(rst_in), .ce_in(ce), .cfg_in(cfg), .evt_in(evt),
    .sw_enable_set_in(sw_set), .sw_enable_clr_in(sw_clr), .flag_clr_in(flag_clr),
    .sleep_clr_in(slp_clr), .idle_clr_in(idl_clr), .sw_watchdog_enable_out(sw_en),
    .timeout_flag_out(flag), .sleep_flag_out(slp), .idle_flag_out(idl),
    .osc_on_out(osc), .wake_out(wake), .device_reset_out(drst), .mode_out(mode)
  );

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : give_verdict

  // Note a pulse expected lo to hi cycles (kind 0 reset, 1 wake) from now
  task automatic expect_pulse(input logic [31:0] kind, input int lo, input int hi);
    notes.push_back('{kind, cyc + lo, cyc + hi});
  endtask : expect_pulse

  // Bounded wait for a pulse; the monitor judges it
  task automatic wait_pulse();
    for (int i = 0; i < P + 2 * TOL && drst !== 1'b1 && wake !== 1'b1; i++) @(negedge clk_in);
    repeat (2) @(negedge clk_in);
  endtask : wait_pulse

  // Every reset or wake pulse must match the oldest note, kind and moment
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (drst === 1'b1 || wake === 1'b1) begin
      if (notes.size() == 0) check("unexpected pulse", 0, 1);
      else begin
        n = notes.pop_front();
        check("pulse kind", {31'h0, wake}, n.kind);
        check("pulse time", {31'h0, cyc >= n.lo && cyc <= n.hi}, 1);
      end
    end
  end

  // Hang guard, reckoned from the tests' total span of about three periods
  initial begin
    repeat (3 * P + 20000) @(posedge clk_in);
    bad_count++;
    $display("watchdog limit reached");
    give_verdict();
  end

  initial begin
    repeat (12) @(negedge clk_in);
    rst_in = 1'b0;
    repeat (2) @(negedge clk_in);
    check("sw enable", sw_en, 0);
    check("oscillator", osc, 1);
    check("mode", mode, 0);
    // Clock switch restarts the period; a random clock-enable stall longer than
    // the phase slack must stretch it, or the pulse lands before the window
    repeat (1000) @(negedge clk_in);
    rnd = lfsr(rnd);
    u_core.issue(u_core.EV_SWTCH);
    expect_pulse(0, P + int'(rnd), P + 2 * TOL + int'(rnd));
    repeat (500) @(negedge clk_in);
    ce = 1'b0;
    repeat (TOL + int'(rnd)) @(negedge clk_in);
    ce = 1'b1;
    wait_pulse();
    check("timeout flag", flag, 1);
    $display("test timeout done");
    // Mid-period clear, then sleep: the clear and the power-save both restart
    // The old count would expire inside the second wait if the clear failed
    rnd = lfsr(rnd);
    repeat (12000 + int'(rnd)) @(negedge clk_in);
    u_core.issue(u_core.EV_CLEAR);
    repeat (15000) @(negedge clk_in);
    u_core.issue(u_core.EV_SLEEP);
    expect_pulse(1, P - TOL, P + TOL);
    repeat (2) @(negedge clk_in);
    check("mode sleep", mode, 2'h1);
    wait_pulse();
    check("mode run", mode, 0);
    check("sleep flag", slp, 1);
    check("flag kept", flag, 1);
    slp_clr = 1'b1;
    flag_clr = 1'b1;
    @(negedge clk_in);
    slp_clr = 1'b0;
    flag_clr = 1'b0;
    repeat (2) @(negedge clk_in);
    check("sleep flag clr", slp, 0);
    check("flag clr", flag, 0);
    $display("test sleep done");
    // Idle entry, then an early wake by another source: no watchdog pulse
    u_core.issue(u_core.EV_IDLE);
    repeat (2) @(negedge clk_in);
    check("mode idle", mode, 2'h2);
    check("idle flag", idl, 1);
    repeat (2000) @(negedge clk_in);
    u_core.issue(u_core.EV_WAKE);
    repeat (2) @(negedge clk_in);
    check("mode after wake", mode, 0);
    check("idle flag kept", idl, 1);
    idl_clr = 1'b1;
    @(negedge clk_in);
    idl_clr = 1'b0;
    repeat (2) @(negedge clk_in);
    check("idle flag clr", idl, 0);
    check("sleep flag in idle", slp, 0);
    $display("test idle done");
    // Window mode under software enable: an early clear resets at once
    cfg = 7'h00;
    rst_in = 1'b1;
    repeat (12) @(negedge clk_in);
    rst_in = 1'b0;
    repeat (2) @(negedge clk_in);
    check("osc off", osc, 0);
    sw_set = 1'b1;
    @(negedge clk_in);
    sw_set = 1'b0;
    repeat (3) @(negedge clk_in);
    check("sw enable on", sw_en, 1);
    check("osc on", osc, 1);
    rnd = lfsr(rnd);
    repeat (100 + int'(rnd)) @(negedge clk_in);
    expect_pulse(0, 0, 4);
    u_core.issue(u_core.EV_CLEAR);
    repeat (6) @(negedge clk_in);
    check("early pulse seen", notes.size(), 0);
    sw_clr = 1'b1;
    @(negedge clk_in);
    sw_clr = 1'b0;
    repeat (3) @(negedge clk_in);
    check("osc off again", osc, 0);
    $display("test window done");
    give_verdict();
  end
endmodule : test_windowed_watchdog_timer
